// ---- logic/drsc_consts.vh ----
// constants for the dual rheostat serial control block
`ifndef DRSC_CONSTS_VH
`define DRSC_CONSTS_VH

// serial word layout
`define DRSC_WORD_BITS 24
`define DRSC_CMD_MSB 23
`define DRSC_CMD_LSB 20
`define DRSC_ADDR_MSB 19
`define DRSC_ADDR_LSB 16
`define DRSC_DATA_MSB 15
`define DRSC_WIPER_MSB 9

// command codes
`define DRSC_CMD_NOP 4'h0
`define DRSC_CMD_RETRIEVE 4'h1
`define DRSC_CMD_SAVE 4'h2
`define DRSC_CMD_STORE_WR 4'h3
`define DRSC_CMD_DEC6 4'h4
`define DRSC_CMD_DEC6_ALL 4'h5
`define DRSC_CMD_DEC1 4'h6
`define DRSC_CMD_DEC1_ALL 4'h7
`define DRSC_CMD_RESET_ALL 4'h8
`define DRSC_CMD_STORE_RD 4'h9
`define DRSC_CMD_WIPER_RD 4'ha
`define DRSC_CMD_WIPER_WR 4'hb
`define DRSC_CMD_INC6 4'hc
`define DRSC_CMD_INC6_ALL 4'hd
`define DRSC_CMD_INC1 4'he
`define DRSC_CMD_INC1_ALL 4'hf

// reset values and wiper limits
`define DRSC_MIDSCALE 16'h0200
`define DRSC_WIPER_MID 10'h200
`define DRSC_WIPER_MAX 10'h3ff
`define DRSC_WIPER_ZERO 10'h000

// timing
// busy time of 100 ns at the 5 ns system clock
`define DRSC_BUSY_CYCLES 8'h14

`endif

// ---- logic/drsc_sync.v ----
// two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module drsc_sync #(
    parameter WIDTH = 5,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // asynchronous in, synchronised out
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_reg;
reg [WIDTH-1:0] sync_reg;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        meta_reg <= INIT;
        sync_reg <= INIT;
    end else begin
        meta_reg <= async_in;
        sync_reg <= meta_reg;
    end
end

assign sync_out = sync_reg;

endmodule

// ---- logic/drsc_top.v ----
// serial control logic of a dual 1024-position rheostat with nonvolatile store
`timescale 1ns/1ps
`include "drsc_consts.vh"
module drsc_top (
    // clock and reset
    input wire clk,
    input wire nrst,
    // serial link pins
    input wire serial_clk,
    input wire serial_in,
    input wire cs_n,
    output wire serial_out_o,
    output wire serial_out_oe,
    // control pins
    input wire wp_n,
    input wire hw_preset_n,
    output wire ready_o,
    output wire ready_oe,
    // wiper settings toward the resistor arrays
    output wire [9:0] wiper_terminal_one,
    output wire [9:0] wiper_terminal_two
);

// ==========================================================
// reset release and pin synchronisation
reg rst_meta_reg;
reg rst_sync_reg;
wire rst_n;

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        rst_meta_reg <= 1'b0;
        rst_sync_reg <= 1'b0;
    end else begin
        rst_meta_reg <= 1'b1;
        rst_sync_reg <= rst_meta_reg;
    end
end

assign rst_n = rst_sync_reg;

wire [4:0] pins_sync;

drsc_sync #(
    .WIDTH(5),
    .INIT(5'h07)
) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({serial_clk, serial_in, cs_n, wp_n, hw_preset_n}),
    .sync_out(pins_sync)
);

wire sclk_s = pins_sync[4];
wire serial_in_s = pins_sync[3];
wire cs_n_s = pins_sync[2];
wire wp_n_s = pins_sync[1];
wire preset_n_s = pins_sync[0];

// ==========================================================
// edge detection on synchronised pins
reg sclk_prev_reg;
reg cs_n_prev_reg;
reg preset_n_prev_reg;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        sclk_prev_reg <= 1'b0;
        cs_n_prev_reg <= 1'b1;
        preset_n_prev_reg <= 1'b1;
    end else begin
        sclk_prev_reg <= sclk_s;
        cs_n_prev_reg <= cs_n_s;
        preset_n_prev_reg <= preset_n_s;
    end
end

wire shift_en = sclk_s & ~sclk_prev_reg & ~cs_n_s;
wire frame_end = cs_n_s & ~cs_n_prev_reg;
wire preset_rise = preset_n_s & ~preset_n_prev_reg;

// ==========================================================
// wiper arithmetic shared by single and all-channel commands
function [9:0] drsc_wiper_step;
    input [3:0] cmd;
    input [9:0] w;
    begin
        case (cmd)
            `DRSC_CMD_DEC6, `DRSC_CMD_DEC6_ALL: begin
                drsc_wiper_step = {1'b0, w[9:1]};
            end
            `DRSC_CMD_DEC1, `DRSC_CMD_DEC1_ALL: begin
                drsc_wiper_step = (w == `DRSC_WIPER_ZERO) ? w : w - 10'h001;
            end
            `DRSC_CMD_INC6, `DRSC_CMD_INC6_ALL: begin
                drsc_wiper_step = w[9] ? `DRSC_WIPER_MAX : {w[8:0], 1'b0};
            end
            `DRSC_CMD_INC1, `DRSC_CMD_INC1_ALL: begin
                drsc_wiper_step = (w == `DRSC_WIPER_MAX) ? w : w + 10'h001;
            end
            default: begin
                drsc_wiper_step = w;
            end
        endcase
    end
endfunction

// ==========================================================
// shift register, store, wipers and command execution
reg [23:0] shift_reg;
reg [15:0] store_mem [0:15];
reg [9:0] wiper_one_reg;
reg [9:0] wiper_two_reg;
reg serial_out_reg;
reg [7:0] busy_cnt_reg;
integer i;

wire [3:0] cmd = shift_reg[`DRSC_CMD_MSB:`DRSC_CMD_LSB];
wire [3:0] addr = shift_reg[`DRSC_ADDR_MSB:`DRSC_ADDR_LSB];
wire [15:0] data = shift_reg[`DRSC_DATA_MSB:0];
wire chan = addr[0];
wire wr_ok = wp_n_s;
wire [9:0] wiper_sel = chan ? wiper_two_reg : wiper_one_reg;

wire single_op = (cmd == `DRSC_CMD_DEC6) || (cmd == `DRSC_CMD_DEC1) ||
                 (cmd == `DRSC_CMD_INC6) || (cmd == `DRSC_CMD_INC1);
wire all_op = (cmd == `DRSC_CMD_DEC6_ALL) || (cmd == `DRSC_CMD_DEC1_ALL) ||
              (cmd == `DRSC_CMD_INC6_ALL) || (cmd == `DRSC_CMD_INC1_ALL);
wire slow_cmd = (cmd == `DRSC_CMD_SAVE) || (cmd == `DRSC_CMD_STORE_WR) ||
                (cmd == `DRSC_CMD_RESET_ALL) || (cmd == `DRSC_CMD_STORE_RD) ||
                (cmd == `DRSC_CMD_WIPER_RD);

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        shift_reg <= 24'h00_0000;
        wiper_one_reg <= `DRSC_WIPER_MID;
        wiper_two_reg <= `DRSC_WIPER_MID;
        serial_out_reg <= 1'b1;
        busy_cnt_reg <= 8'h00;
        for (i = 0; i < 16; i = i + 1) begin
            store_mem[i] <= (i < 2) ? `DRSC_MIDSCALE : 16'h0000;
        end
    end else begin
        if (busy_cnt_reg != 8'h00) begin
            busy_cnt_reg <= busy_cnt_reg - 8'h01;
        end
        if (shift_en) begin
            shift_reg <= {shift_reg[22:0], serial_in_s};
            serial_out_reg <= shift_reg[23];
        end
        if (preset_rise) begin
            wiper_one_reg <= store_mem[0][9:0];
            wiper_two_reg <= store_mem[1][9:0];
            busy_cnt_reg <= `DRSC_BUSY_CYCLES;
        end else if (frame_end) begin
            if (slow_cmd) begin
                busy_cnt_reg <= `DRSC_BUSY_CYCLES;
            end
            case (cmd)
                `DRSC_CMD_RETRIEVE: begin
                    if (chan) begin
                        wiper_two_reg <= store_mem[1][9:0];
                    end else begin
                        wiper_one_reg <= store_mem[0][9:0];
                    end
                end
                `DRSC_CMD_SAVE: begin
                    if (wr_ok) begin
                        store_mem[{3'h0, chan}] <= {6'h00, wiper_sel};
                    end
                end
                `DRSC_CMD_STORE_WR: begin
                    if (wr_ok) begin
                        store_mem[addr] <= data;
                    end
                end
                `DRSC_CMD_RESET_ALL: begin
                    wiper_one_reg <= store_mem[0][9:0];
                    wiper_two_reg <= store_mem[1][9:0];
                end
                `DRSC_CMD_STORE_RD: begin
                    shift_reg[15:0] <= store_mem[addr];
                end
                `DRSC_CMD_WIPER_RD: begin
                    shift_reg[15:0] <= {6'h00, wiper_sel};
                end
                `DRSC_CMD_WIPER_WR: begin
                    if (wr_ok && chan) begin
                        wiper_two_reg <= data[`DRSC_WIPER_MSB:0];
                    end else if (wr_ok) begin
                        wiper_one_reg <= data[`DRSC_WIPER_MSB:0];
                    end
                end
                default: begin
                    if (wr_ok && single_op && chan) begin
                        wiper_two_reg <= drsc_wiper_step(cmd, wiper_two_reg);
                    end else if (wr_ok && single_op) begin
                        wiper_one_reg <= drsc_wiper_step(cmd, wiper_one_reg);
                    end else if (wr_ok && all_op) begin
                        wiper_one_reg <= drsc_wiper_step(cmd, wiper_one_reg);
                        wiper_two_reg <= drsc_wiper_step(cmd, wiper_two_reg);
                    end
                end
            endcase
        end
    end
end

// ==========================================================
// open-drain pins: enable pulls the wire low
assign serial_out_o = 1'b0;
assign serial_out_oe = ~cs_n_s & ~serial_out_reg;
assign ready_o = 1'b0;
assign ready_oe = (busy_cnt_reg != 8'h00);

assign wiper_terminal_one = wiper_one_reg;
assign wiper_terminal_two = wiper_two_reg;

endmodule

// ---- test/drsc_top_props.sv ----
// checker for the serial control pins
`timescale 1ns/1ps
module drsc_top_props (
    // clock and reset
    input wire clk,
    input wire nrst,
    // pins
    input wire cs_n,
    input wire hw_preset_n,
    input wire serial_out_o,
    input wire serial_out_oe,
    input wire ready_o,
    input wire ready_oe,
    input wire [9:0] wiper_terminal_one,
    input wire [9:0] wiper_terminal_two
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_busy;
        ready_oe[*8] ##1 ready_oe[*8] ##1 ready_oe[*4] ##1 !ready_oe;
    endsequence
    sequence s_quiet;
        (!cs_n && hw_preset_n)[*8];
    endsequence
    property p_busy; $rose(ready_oe) |-> s_busy; endproperty
    property p_pre; $rose(hw_preset_n) |-> ##[2:6] ready_oe; endproperty
    property p_idle; cs_n[*5] |-> !serial_out_oe; endproperty
    property p_od; !ready_o && !serial_out_o; endproperty
    property p_hold;
        s_quiet |-> $stable(wiper_terminal_one) && $stable(wiper_terminal_two);
    endproperty
    property p_chg;
        $changed(wiper_terminal_one) || $changed(wiper_terminal_two) |-> cs_n;
    endproperty
    property p_cause; $rose(ready_oe) |-> cs_n; endproperty
    property p_frame; $rose(serial_out_oe) |-> !cs_n; endproperty
    a_busy: assert property (p_busy) else $error("busy len");
    a_pre: assert property (p_pre) else $error("preset");
    a_idle: assert property (p_idle) else $error("serial out idle");
    a_od: assert property (p_od) else $error("od level");
    a_hold: assert property (p_hold) else $error("wiper moved");
    a_chg: assert property (p_chg) else $error("early exec");
    a_cause: assert property (p_cause) else $error("ready cause");
    a_frame: assert property (p_frame) else $error("serial out frame");
endmodule
bind drsc_top drsc_top_props drsc_top_props_i (.clk(clk), .nrst(nrst), .cs_n(cs_n),
    .hw_preset_n(hw_preset_n), .serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe),
    .ready_o(ready_o), .ready_oe(ready_oe), .wiper_terminal_one(wiper_terminal_one),
    .wiper_terminal_two(wiper_terminal_two));

// ---- test/drsc_host.sv ----
// host model driving the serial link
`timescale 1ns/1ps
module drsc_host (
    // clock
    input wire clk,
    // link
    input wire so_w,
    output logic serial_clk,
    output logic serial_in,
    output logic cs_n
);
    initial begin
        serial_clk = 1'b0;
        serial_in = 1'b0;
        cs_n = 1'b1;
    end
    task automatic frame(input logic [23:0] w, output logic [23:0] got);
        @(negedge clk) cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            serial_in = w[i];
            repeat (16) @(negedge clk);
            serial_clk = 1'b1;
            repeat (15) @(negedge clk);
            got[i] = so_w;
            @(negedge clk) serial_clk = 1'b0;
        end
        repeat (8) @(negedge clk);
        cs_n = 1'b1;
        serial_in = ~serial_in;
    endtask
    // clocks with chip select high must be ignored
    task automatic noise(input int n);
        repeat (n) begin
            repeat (8) @(negedge clk);
            serial_in = ~serial_in;
            serial_clk = ~serial_clk;
        end
    endtask
endmodule

// ---- test/drsc_top_bench.sv ----
// self-checking bench for the serial control block
`timescale 1ns/1ps
module drsc_top_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wp_n = 1'b1;
    logic hw_preset_n = 1'b1;
    logic [3:0] kc;
    logic [23:0] expo, got, w;
    wire serial_clk, serial_in, cs_n, serial_out_o, serial_out_oe, ready_o, ready_oe;
    wire [9:0] wiper_terminal_one, wiper_terminal_two;
    wire so_w = serial_out_oe ? serial_out_o : 1'b1;
    int error_cnt = 0;
    int n_checks = 0;
    int mw[2];
    int ms[16];
    always #2.5 clk = ~clk;
    drsc_top drsc_top_i (.clk(clk), .nrst(nrst), .serial_clk(serial_clk),
        .serial_in(serial_in), .cs_n(cs_n), .serial_out_o(serial_out_o),
        .serial_out_oe(serial_out_oe), .wp_n(wp_n), .hw_preset_n(hw_preset_n),
        .ready_o(ready_o), .ready_oe(ready_oe), .wiper_terminal_one(wiper_terminal_one),
        .wiper_terminal_two(wiper_terminal_two));
    drsc_host drsc_host_i (.clk(clk), .so_w(so_w), .serial_clk(serial_clk),
        .serial_in(serial_in), .cs_n(cs_n));
    task automatic check(input string s, input logic [23:0] e, input logic [23:0] v);
        n_checks++;
        if (v !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", s, e, v);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic model(input logic [23:0] w);
        int c, a, v;
        logic sel;
        c = w[23:20];
        a = w[16];
        for (int i = 0; i < 2; i++) begin
            v = mw[i];
            sel = wp_n && (i == a || c inside {5, 7, 13, 15});
            case (c)
                1: if (i == a) v = ms[i] % 1024;
                8: v = ms[i] % 1024;
                11: if (sel) v = w[9:0];
                4, 5: if (sel) v = v / 2;
                6, 7: if (sel && v > 0) v--;
                12, 13: if (sel) v = v > 511 ? 1023 : v * 2;
                14, 15: if (sel && v < 1023) v++;
                default: ;
            endcase
            mw[i] = v;
        end
        if (wp_n && c == 2) ms[a] = mw[a];
        if (wp_n && c == 3) ms[w[19:16]] = w[15:0];
    endtask
    task automatic settle(input logic busy);
        logic saw;
        saw = 1'b0;
        repeat (10) @(negedge clk) saw = saw | ready_oe;
        if (wp_n) check("ready", busy, saw);
        repeat (22) @(negedge clk);
        check("ready end", 0, ready_oe);
        check("wiper one", mw[0], wiper_terminal_one);
        check("wiper two", mw[1], wiper_terminal_two);
    endtask
    initial begin
        void'($urandom(32'ha329_c5f5));
        ms = '{default: 0};
        ms[0] = 512;
        ms[1] = 512;
        mw = '{512, 512};
        expo = 24'h00_0000;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        repeat (8) @(negedge clk);
        settle(1'b0);
        for (int k = 0; k < 40; k++) begin
            kc = (k == 19) ? 4'h0 : 4'(k < 16 ? k : $urandom);
            wp_n = !(k >= 10 && k < 20);
            w = {kc, 3'b000, 1'($urandom), 16'($urandom)};
            if (kc == 3 || kc == 9) w[19:16] = 4'($urandom);
            drsc_host_i.frame(w, got);
            check("serial out", expo, got);
            model(w);
            // readback words keep the instruction byte and carry the register below it
            expo = kc == 9 ? {w[23:16], 16'(ms[w[19:16]])} :
                   kc == 10 ? {w[23:16], 16'(mw[w[16]])} : w;
            settle(kc inside {2, 3, 8, 9, 10});
            if ($urandom % 2) drsc_host_i.noise(6);
            if (k % 9 == 4) begin
                hw_preset_n = 1'b0;
                repeat (10) @(negedge clk);
                hw_preset_n = 1'b1;
                mw[0] = ms[0] % 1024;
                mw[1] = ms[1] % 1024;
                settle(1'b1);
            end
        end
        complete_run();
    end
endmodule
